/* core/rtcf_pkg.sv */
// Constants for the reset timers and reset-cause flags block
package rtcf_pkg;
  // Clock and delay timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int XTAL_STARTUP_OSC_CYCLES = 1024;
  localparam int PLL_LOCK_TIME_NS = 2000;
  localparam int PLL_LOCK_CYCLES = (PLL_LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XTAL_CNT_W = 11;
  localparam int PLL_CNT_W = 10;

  // Oscillator selection field codes
  localparam logic [2:0] OSC_LOW_POWER_CRYSTAL_MODE = 3'h0;
  localparam logic [2:0] OSC_MEDIUM_CRYSTAL_MODE = 3'h1;
  localparam logic [2:0] OSC_HIGH_SPEED_CRYSTAL_MODE = 3'h2;
  localparam logic [2:0] OSC_HIGH_SPEED_WITH_PLL_MODE = 3'h3;

  // Power mode codes
  localparam logic [1:0] PM_RUN = 2'h0;
  localparam logic [1:0] PM_IDLE = 2'h1;
  localparam logic [1:0] PM_SLEEP = 2'h2;

  // Cause flag positions, one-bit masks
  localparam int FLAG_W = 13;
  localparam logic [12:0] M_CORE_BOR = 13'h0001;
  localparam logic [12:0] M_CORE_POR = 13'h0002;
  localparam logic [12:0] M_IDLE = 13'h0004;
  localparam logic [12:0] M_PD = 13'h0008;
  localparam logic [12:0] M_WDT = 13'h0010;
  localparam logic [12:0] M_RI = 13'h0020;
  localparam logic [12:0] M_EXTERNAL_RESET_FLAG = 13'h0040;
  localparam logic [12:0] M_CM = 13'h0080;
  localparam logic [12:0] M_DEEP_SLEEP_FLAG = 13'h0100;
  localparam logic [12:0] M_VDD_BOR = 13'h0200;
  localparam logic [12:0] M_VDD_POR = 13'h0400;
  localparam logic [12:0] M_BATTERY_RESET_FLAG = 13'h0800;
  localparam logic [12:0] M_VBAT = 13'h1000;
  localparam logic [12:0] M_LOW_CLR = M_EXTERNAL_RESET_FLAG | M_RI | M_WDT | M_IDLE | M_CM;

  // Flag value after reset_n: first power-up state
  localparam logic [12:0] FLAGS_RESET = M_PD | M_CORE_BOR | M_CORE_POR | M_VDD_BOR |
                                        M_VDD_POR | M_BATTERY_RESET_FLAG;

  // Resume action codes, one-hot
  localparam logic [2:0] RESUME_ZERO = 3'h1;
  localparam logic [2:0] RESUME_PC_PLUS2 = 3'h2;
  localparam logic [2:0] RESUME_VECTOR = 3'h4;
  localparam logic [2:0] RESUME_NONE = 3'h0;

  // Register reset class codes, one-hot
  localparam logic [2:0] CLASS_POWER = 3'h1;
  localparam logic [2:0] CLASS_HARD = 3'h2;
  localparam logic [2:0] CLASS_WAKE = 3'h4;
  localparam logic [2:0] CLASS_NONE = 3'h0;

  // Start-up sequencer states
  typedef enum logic [3:0] {
    SEQ_POWERUP = 4'h1,
    SEQ_XTAL = 4'h2,
    SEQ_PLL = 4'h4,
    SEQ_RUN = 4'h8
  } rtcf_seq_t;
endpackage : rtcf_pkg

/* core/rtcf_reset_timers.sv */
// Start-up delay chain and reset-cause flag register
`timescale 1ns/1ps
module rtcf_reset_timers (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // External oscillator input pin
  input wire logic oscInputPin,
  // Configuration and power-up delay counter status
  input wire logic [2:0] oscillatorSelectField,
  input wire logic powerupDelayDone,
  input wire logic [1:0] powerMode,
  input wire logic globalInterruptEnable,
  input wire logic watchdogWindowEnable,
  input wire logic watchdogInSafeWindow,
  // Reset and wake-up event pulses
  input wire logic deepSleepPoweronEvent,
  input wire logic batteryModeEvent,
  input wire logic supplyPoweronEvent,
  input wire logic supplyBrownoutEvent,
  input wire logic corePoweronEvent,
  input wire logic coreBrownoutEvent,
  input wire logic deepSleepExitEvent,
  input wire logic retentionDeepSleepExitEvent,
  input wire logic powerManagedExitEvent,
  input wire logic masterClearPinEvent,
  input wire logic configMismatchEvent,
  input wire logic resetInstructionEvent,
  input wire logic watchdogEvent,
  input wire logic interruptWakeEvent,
  // Instruction pulses
  input wire logic clearWatchdogInstruction,
  input wire logic idleInstruction,
  input wire logic sleepInstruction,
  // Software access to the cause flags
  input wire logic flagWriteStrobe,
  input wire logic [rtcf_pkg::FLAG_W-1:0] flagWriteData,
  // Status and control outputs
  output logic [rtcf_pkg::FLAG_W-1:0] resetCauseFlags,
  output logic executionHold,
  output logic pllEnable,
  output logic crystalDelayActive,
  output logic pllLockActive,
  output logic [2:0] resumeAction,
  output logic [2:0] resetClass,
  output logic resumeValid
);
  import rtcf_pkg::*;

  function automatic logic [FLAG_W-1:0] applyMasks(
    input logic [FLAG_W-1:0] cur,
    input logic [FLAG_W-1:0] setM,
    input logic [FLAG_W-1:0] clrM
  );
    applyMasks = (cur & ~clrM) | setM;
  endfunction : applyMasks

  function automatic logic isCrystalMode(input logic [2:0] sel);
    isCrystalMode = (sel == OSC_LOW_POWER_CRYSTAL_MODE) || (sel == OSC_MEDIUM_CRYSTAL_MODE) ||
                    (sel == OSC_HIGH_SPEED_CRYSTAL_MODE) || (sel == OSC_HIGH_SPEED_WITH_PLL_MODE);
  endfunction : isCrystalMode

  // Oscillator pin synchroniser and edge filter
  logic oscSync1_q;
  logic oscSync2_q;
  logic oscSync3_q;
  logic oscLevel_q;
  logic oscRise;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oscSync1_q <= 1'b0;
      oscSync2_q <= 1'b0;
      oscSync3_q <= 1'b0;
    end else begin
      oscSync1_q <= oscInputPin;
      oscSync2_q <= oscSync1_q;
      oscSync3_q <= oscSync2_q;
    end
  end

  // A change only counts once two stages agree
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      oscLevel_q <= 1'b0;
    end else if (oscSync2_q == oscSync3_q) begin
      oscLevel_q <= oscSync3_q;
    end
  end

  assign oscRise = (oscSync2_q == oscSync3_q) && oscSync3_q && !oscLevel_q;

  // Event classification
  logic porLike;
  logic borLike;
  logic seqStart;
  logic pllSelected;

  assign porLike = deepSleepPoweronEvent | batteryModeEvent | supplyPoweronEvent |
                   corePoweronEvent | deepSleepExitEvent | retentionDeepSleepExitEvent;
  assign borLike = supplyBrownoutEvent | coreBrownoutEvent;
  assign seqStart = porLike | borLike | powerManagedExitEvent;
  assign pllSelected = (oscillatorSelectField == OSC_HIGH_SPEED_WITH_PLL_MODE);

  // Start-up sequencer
  rtcf_seq_t seqState_q;
  logic seqFromPor_q;
  logic seqXtal_q;
  logic [XTAL_CNT_W-1:0] xtalCount_q;
  logic [PLL_CNT_W-1:0] pllCount_q;
  logic xtalDone;
  logic pllDone;

  assign xtalDone = oscRise && (xtalCount_q == XTAL_CNT_W'(XTAL_STARTUP_OSC_CYCLES - 1));
  assign pllDone = (pllCount_q == PLL_CNT_W'(PLL_LOCK_CYCLES - 1));

  // Which delays this sequence will run, captured at its start
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seqFromPor_q <= 1'b1;
      seqXtal_q <= 1'b1;
    end else if (seqStart) begin
      seqFromPor_q <= porLike;
      seqXtal_q <= porLike | powerManagedExitEvent;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seqState_q <= SEQ_POWERUP;
    end else if (porLike || borLike) begin
      seqState_q <= SEQ_POWERUP;
    end else if (powerManagedExitEvent) begin
      seqState_q <= SEQ_XTAL;
    end else begin
      unique case (seqState_q)
        SEQ_POWERUP: begin
          if (powerupDelayDone) begin
            seqState_q <= (seqXtal_q && isCrystalMode(oscillatorSelectField)) ? SEQ_XTAL :
                          SEQ_RUN;
          end
        end
        SEQ_XTAL: begin
          if (!isCrystalMode(oscillatorSelectField)) begin
            seqState_q <= SEQ_RUN;
          end else if (xtalDone) begin
            seqState_q <= (seqFromPor_q && pllSelected) ? SEQ_PLL : SEQ_RUN;
          end
        end
        SEQ_PLL: begin
          if (pllDone) begin
            seqState_q <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          seqState_q <= SEQ_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || seqState_q != SEQ_XTAL || seqStart) begin
      xtalCount_q <= '0;
    end else if (oscRise) begin
      xtalCount_q <= xtalCount_q + XTAL_CNT_W'(1);
    end
  end

  // PLL lock delay runs on the system clock, independent of the crystal
  always_ff @(posedge clk) begin
    if (!reset_n || seqState_q != SEQ_PLL || seqStart) begin
      pllCount_q <= '0;
    end else begin
      pllCount_q <= pllCount_q + PLL_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      executionHold <= 1'b1;
      crystalDelayActive <= 1'b0;
      pllLockActive <= 1'b0;
      pllEnable <= 1'b0;
    end else begin
      executionHold <= seqStart || (seqState_q != SEQ_RUN);
      crystalDelayActive <= (seqState_q == SEQ_XTAL) && !seqStart;
      pllLockActive <= (seqState_q == SEQ_PLL) && !seqStart;
      pllEnable <= pllSelected;
    end
  end

  // Cause flag event decode
  logic [FLAG_W-1:0] hwSet;
  logic [FLAG_W-1:0] hwClr;
  logic [2:0] actionNext;
  logic [2:0] classNext;

  always_comb begin
    hwSet = '0;
    hwClr = '0;
    actionNext = RESUME_NONE;
    classNext = CLASS_NONE;
    if (deepSleepPoweronEvent) begin
      hwSet = M_PD | M_CORE_BOR | M_CORE_POR | M_VDD_BOR | M_VDD_POR | M_BATTERY_RESET_FLAG;
      hwClr = M_LOW_CLR | M_DEEP_SLEEP_FLAG | M_VBAT;
      actionNext = RESUME_ZERO;
      classNext = CLASS_POWER;
    end else if (batteryModeEvent) begin
      hwSet = M_DEEP_SLEEP_FLAG | M_PD | M_CORE_BOR | M_CORE_POR | M_VDD_BOR | M_VDD_POR | M_VBAT;
      hwClr = M_LOW_CLR;
      actionNext = RESUME_ZERO;
      classNext = CLASS_POWER;
    end else if (supplyPoweronEvent) begin
      hwSet = M_PD | M_CORE_BOR | M_CORE_POR | M_VDD_BOR | M_VDD_POR;
      hwClr = M_LOW_CLR | M_DEEP_SLEEP_FLAG;
      actionNext = RESUME_ZERO;
      classNext = CLASS_POWER;
    end else if (corePoweronEvent) begin
      hwSet = M_PD | M_CORE_BOR | M_CORE_POR;
      hwClr = M_LOW_CLR | M_DEEP_SLEEP_FLAG;
      actionNext = RESUME_ZERO;
      classNext = CLASS_POWER;
    end else if (supplyBrownoutEvent) begin
      hwSet = M_PD | M_VDD_BOR;
      hwClr = M_RI | M_WDT | M_IDLE | M_CM;
      actionNext = RESUME_ZERO;
      classNext = CLASS_POWER;
    end else if (coreBrownoutEvent) begin
      hwSet = M_PD | M_CORE_BOR;
      hwClr = M_RI | M_WDT | M_IDLE | M_CM;
      actionNext = RESUME_ZERO;
      classNext = CLASS_POWER;
    end else if (deepSleepExitEvent) begin
      hwSet = M_DEEP_SLEEP_FLAG | M_PD | M_CORE_BOR | M_CORE_POR;
      hwClr = M_LOW_CLR;
      actionNext = RESUME_ZERO;
      classNext = CLASS_POWER;
    end else if (retentionDeepSleepExitEvent) begin
      hwSet = M_DEEP_SLEEP_FLAG | M_PD;
      hwClr = M_LOW_CLR | M_CORE_BOR | M_CORE_POR;
      actionNext = RESUME_ZERO;
      classNext = CLASS_POWER;
    end else if (masterClearPinEvent) begin
      hwSet = M_EXTERNAL_RESET_FLAG;
      if (powerMode == PM_IDLE) begin
        hwSet = M_EXTERNAL_RESET_FLAG | M_IDLE;
        hwClr = M_WDT | M_PD;
      end else if (powerMode == PM_SLEEP) begin
        hwClr = M_WDT | M_PD | M_IDLE;
      end
      actionNext = RESUME_ZERO;
      classNext = CLASS_HARD;
    end else if (configMismatchEvent) begin
      hwSet = M_CM;
      actionNext = RESUME_ZERO;
      classNext = CLASS_HARD;
    end else if (resetInstructionEvent) begin
      hwSet = M_RI;
      actionNext = RESUME_ZERO;
      classNext = CLASS_HARD;
    end else if (watchdogEvent) begin
      if (powerMode == PM_IDLE) begin
        hwSet = M_WDT | M_PD | M_IDLE;
        actionNext = RESUME_PC_PLUS2;
        classNext = CLASS_WAKE;
      end else if (powerMode == PM_SLEEP) begin
        hwSet = M_WDT;
        hwClr = M_PD | M_IDLE;
        actionNext = RESUME_PC_PLUS2;
        classNext = CLASS_WAKE;
      end else begin
        hwSet = M_WDT;
        actionNext = RESUME_ZERO;
        classNext = CLASS_HARD;
      end
    end else if (interruptWakeEvent && powerMode != PM_RUN) begin
      if (powerMode == PM_IDLE) begin
        hwSet = M_PD | M_IDLE;
        hwClr = M_WDT;
      end else begin
        hwClr = M_WDT | M_PD | M_IDLE;
      end
      actionNext = globalInterruptEnable ? RESUME_VECTOR : RESUME_PC_PLUS2;
      classNext = CLASS_WAKE;
    end else if (clearWatchdogInstruction) begin
      hwSet = M_PD;
      hwClr = (!watchdogWindowEnable || watchdogInSafeWindow) ? M_WDT : '0;
      actionNext = RESUME_PC_PLUS2;
    end else if (idleInstruction) begin
      hwSet = M_PD | M_IDLE;
      hwClr = M_WDT;
      actionNext = RESUME_PC_PLUS2;
    end else if (sleepInstruction) begin
      hwClr = M_WDT | M_PD | M_IDLE;
      actionNext = RESUME_PC_PLUS2;
    end
  end

  // Software write view: down flag inverted, deep-sleep only clears,
  // battery flags only clear
  logic [FLAG_W-1:0] swSet;
  logic [FLAG_W-1:0] swClr;

  always_comb begin
    swSet = '0;
    swClr = '0;
    if (flagWriteStrobe) begin
      swSet = flagWriteData & ~(M_PD | M_DEEP_SLEEP_FLAG | M_BATTERY_RESET_FLAG | M_VBAT);
      swClr = ~flagWriteData & ~M_PD;
      if (flagWriteData[3]) begin
        swClr = swClr | M_PD;
      end else begin
        swSet = swSet | M_PD;
      end
    end
  end

  // Hardware applied last so an event beats a same-cycle software clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      resetCauseFlags <= FLAGS_RESET;
    end else begin
      resetCauseFlags <= applyMasks(applyMasks(resetCauseFlags, swSet, swClr),
                                    hwSet, hwClr);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      resumeAction <= RESUME_ZERO;
      resetClass <= CLASS_POWER;
      resumeValid <= 1'b0;
    end else begin
      resumeValid <= (actionNext != RESUME_NONE);
      if (actionNext != RESUME_NONE) begin
        resumeAction <= actionNext;
        resetClass <= classNext;
      end
    end
  end
endmodule : rtcf_reset_timers

/* sim/rtcf_reset_timers_sva.sv */
// Concurrent checks on the reset timers and cause flags ports
`timescale 1ns/1ps
module rtcf_reset_timers_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Modes
  input wire logic [2:0] oscillatorSelectField,
  input wire logic [1:0] powerMode,
  input wire logic globalInterruptEnable,
  input wire logic watchdogWindowEnable,
  input wire logic watchdogInSafeWindow,
  // Events and writes
  input wire logic deepSleepPoweronEvent,
  input wire logic batteryModeEvent,
  input wire logic powerManagedExitEvent,
  input wire logic masterClearPinEvent,
  input wire logic watchdogEvent,
  input wire logic interruptWakeEvent,
  input wire logic clearWatchdogInstruction,
  input wire logic sleepInstruction,
  input wire logic flagWriteStrobe,
  input wire logic [rtcf_pkg::FLAG_W-1:0] flagWriteData,
  // Outputs
  input wire logic [rtcf_pkg::FLAG_W-1:0] resetCauseFlags,
  input wire logic executionHold,
  input wire logic pllEnable,
  input wire logic crystalDelayActive,
  input wire logic pllLockActive,
  input wire logic [2:0] resumeAction,
  input wire logic resumeValid
);
  import rtcf_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  localparam logic [12:0] TRIO = M_WDT | M_PD | M_IDLE;
  localparam logic [12:0] BATS = M_BATTERY_RESET_FLAG | M_VBAT;
  wire [12:0] fl = resetCauseFlags;
  // Higher-priority events and writes would mask the one under test
  sequence lone(e);
    e && !flagWriteStrobe && !deepSleepPoweronEvent;
  endsequence
  sequence kept(m);
    (fl & m) == $past(fl & m);
  endsequence
  wdt_idle_wake_a: assert property (lone(watchdogEvent && powerMode == PM_IDLE) |=>
    (fl & TRIO) == TRIO && resumeAction == RESUME_PC_PLUS2 && resumeValid)
    else $error("watchdog idle wake flags wrong");
  wdt_sleep_wake_a: assert property (lone(watchdogEvent && powerMode == PM_SLEEP) |=>
    (fl & TRIO) == M_WDT && resumeAction == RESUME_PC_PLUS2)
    else $error("watchdog sleep wake flags wrong");
  master_clear_pin_sleep_a: assert property (lone(masterClearPinEvent && powerMode == PM_SLEEP) |=>
    (fl & (TRIO | M_EXTERNAL_RESET_FLAG)) == M_EXTERNAL_RESET_FLAG && resumeAction == RESUME_ZERO ##0 kept(~(TRIO | M_EXTERNAL_RESET_FLAG)))
    else $error("master clear in sleep flags wrong");
  int_vector_a: assert property (lone(interruptWakeEvent && powerMode != PM_RUN &&
    globalInterruptEnable) |=> resumeAction == RESUME_VECTOR && (fl & M_WDT) == 0)
    else $error("interrupt wake did not vector");
  int_run_ignored_a: assert property (lone(interruptWakeEvent && powerMode == PM_RUN) |=>
    kept(13'h1fff) ##0 !resumeValid)
    else $error("interrupt in run changed state");
  sleep_instr_a: assert property (lone(sleepInstruction) |=> (fl & TRIO) == 0 ##0 kept(~TRIO))
    else $error("sleep instruction flags wrong");
  clear_watchdog_instruction_flags_a: assert property (lone(clearWatchdogInstruction) |=> (fl & M_PD) != 0 &&
    fl[4] == ($past(fl[4]) && $past(watchdogWindowEnable && !watchdogInSafeWindow)))
    else $error("clear watchdog flags wrong");
  batt_write_a: assert property (flagWriteStrobe && !batteryModeEvent &&
    !deepSleepPoweronEvent |=> (fl & BATS & ~$past(fl)) == 0)
    else $error("software set a battery flag");
  batt_mode_a: assert property (lone(batteryModeEvent) |=> (fl & ~M_BATTERY_RESET_FLAG) ==
    (M_DEEP_SLEEP_FLAG | M_PD | M_CORE_BOR | M_CORE_POR | M_VDD_BOR | M_VDD_POR | M_VBAT))
    else $error("battery mode flags wrong");
  pll_select_a: assert property (reset_n |=>
    pllEnable == ($past(oscillatorSelectField) == OSC_HIGH_SPEED_WITH_PLL_MODE))
    else $error("pll enable does not follow select");
  pm_exit_xtal_a: assert property (powerManagedExitEvent &&
    oscillatorSelectField <= OSC_HIGH_SPEED_WITH_PLL_MODE |=>
    executionHold ##1 executionHold && crystalDelayActive && !pllLockActive)
    else $error("power-managed exit skipped crystal delay");
endmodule : rtcf_reset_timers_sva

bind rtcf_reset_timers rtcf_reset_timers_sva rtcf_reset_timers_sva_i (.*);

/* sim/test_rtcf_reset_timers.sv */
// Self-checking bench for the reset timers and cause flags block
`timescale 1ns/1ps
module test_rtcf_reset_timers;
  import rtcf_pkg::*;
  `define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
    $display("[ERR] %s expected %h seen %h", n, e, s); end end
  localparam logic [12:0] TRIO = M_WDT | M_PD | M_IDLE;
  localparam logic [12:0] CORE = M_CORE_BOR | M_CORE_POR;
  localparam logic [12:0] PWR = M_PD | CORE;
  logic clk = 0, reset_n = 0, osc = 0, pud = 0, global_interrupt_enable = 0, we = 0, safe = 0, pmx = 0, wst = 0;
  logic [2:0] sel = 3'h5;
  logic [1:0] pm = PM_RUN;
  logic [15:0] ev = '0;
  logic [FLAG_W-1:0] wd = '0, fl;
  logic hold, pllEn, xact, pact, rv;
  logic [2:0] ra, rc;
  int fails = 0, comparisons = 0, xEdges = 0;
  initial forever #2 clk = ~clk;
  // Free-running crystal, deliberately off the clock grid
  initial forever #8.3 osc = ~osc;
  always @(posedge osc) if (xact === 1'b1) xEdges++;
  rtcf_reset_timers rtcf_reset_timers_i (
    .clk(clk), .reset_n(reset_n), .oscInputPin(osc), .oscillatorSelectField(sel),
    .powerupDelayDone(pud), .powerMode(pm), .globalInterruptEnable(global_interrupt_enable),
    .watchdogWindowEnable(we), .watchdogInSafeWindow(safe),
    .deepSleepPoweronEvent(ev[0]), .batteryModeEvent(ev[1]), .supplyPoweronEvent(ev[2]),
    .corePoweronEvent(ev[3]), .supplyBrownoutEvent(ev[4]), .coreBrownoutEvent(ev[5]),
    .deepSleepExitEvent(ev[6]), .retentionDeepSleepExitEvent(ev[7]),
    .powerManagedExitEvent(pmx), .masterClearPinEvent(ev[8]), .configMismatchEvent(ev[9]),
    .resetInstructionEvent(ev[10]), .watchdogEvent(ev[11]), .interruptWakeEvent(ev[12]),
    .clearWatchdogInstruction(ev[13]), .idleInstruction(ev[14]), .sleepInstruction(ev[15]),
    .flagWriteStrobe(wst), .flagWriteData(wd), .resetCauseFlags(fl), .executionHold(hold),
    .pllEnable(pllEn), .crystalDelayActive(xact), .pllLockActive(pact),
    .resumeAction(ra), .resetClass(rc), .resumeValid(rv));
  function automatic logic [FLAG_W-1:0] nextFlags(logic [FLAG_W-1:0] c, int e, logic w,
      logic [FLAG_W-1:0] d);
    logic [FLAG_W-1:0] s, k, bat;
    bat = M_DEEP_SLEEP_FLAG | M_BATTERY_RESET_FLAG | M_VBAT;
    s = '0;
    k = '0;
    // Write lands first, a same-cycle event overrides its bits
    if (w) c = ((d ^ M_PD) & ~bat) | (c & d & bat);
    case (e)
      0: begin s = PWR | M_VDD_BOR | M_VDD_POR | M_BATTERY_RESET_FLAG; k = M_DEEP_SLEEP_FLAG | M_LOW_CLR | M_VBAT; end
      1: begin s = M_DEEP_SLEEP_FLAG | PWR | M_VDD_BOR | M_VDD_POR | M_VBAT; k = M_LOW_CLR; end
      2: begin s = PWR | M_VDD_BOR | M_VDD_POR; k = M_DEEP_SLEEP_FLAG | M_LOW_CLR; end
      3: begin s = PWR; k = M_DEEP_SLEEP_FLAG | M_LOW_CLR; end
      4, 5: begin s = M_PD | (e == 4 ? M_VDD_BOR : M_CORE_BOR); k = M_LOW_CLR & ~M_EXTERNAL_RESET_FLAG; end
      6: begin s = M_DEEP_SLEEP_FLAG | PWR; k = M_LOW_CLR; end
      7: begin s = M_DEEP_SLEEP_FLAG | M_PD; k = M_LOW_CLR | CORE; end
      8: begin s = M_EXTERNAL_RESET_FLAG | (pm == PM_IDLE ? M_IDLE : 13'h0000);
        k = pm == PM_RUN ? 13'h0000 : TRIO & ~s; end
      9: s = M_CM;
      10: s = M_RI;
      11: begin s = pm == PM_IDLE ? TRIO : M_WDT; k = pm == PM_SLEEP ? M_PD | M_IDLE : 13'h0000; end
      12: if (pm != PM_RUN) begin s = pm == PM_IDLE ? M_PD | M_IDLE : 13'h0000; k = TRIO & ~s; end
      13: begin s = M_PD; k = (!we || safe) ? M_WDT : 13'h0000; end
      14: begin s = M_PD | M_IDLE; k = M_WDT; end
      15: k = TRIO;
      default: ;
    endcase
    return (c & ~k) | s;
  endfunction : nextFlags
  function automatic logic [5:0] nextResume(int e);
    if (e <= 7) return {CLASS_POWER, RESUME_ZERO};
    if (e <= 10 || (e == 11 && pm == PM_RUN)) return {CLASS_HARD, RESUME_ZERO};
    if (e == 11) return {CLASS_WAKE, RESUME_PC_PLUS2};
    return {CLASS_WAKE, global_interrupt_enable ? RESUME_VECTOR : RESUME_PC_PLUS2};
  endfunction : nextResume
  task automatic step(int e, logic w, logic [FLAG_W-1:0] d);
    logic [FLAG_W-1:0] want;
    want = nextFlags(fl, e, w, d);
    if (e < 16) ev[e] = 1'b1;
    wst = w;
    wd = d;
    @(posedge clk);
    #1;
    ev = '0;
    wst = 0;
    `CHK("flags", want, fl)
    if (e <= 12 && !(e == 12 && pm == PM_RUN)) begin
      `CHK("resume", nextResume(e), {rc, ra})
      `CHK("resumeValid", 1'b1, rv)
    end
  endtask : step
  task automatic startup(logic [2:0] mode, int e, int wantX, int wantP);
    int pc, n;
    pc = 0;
    n = 0;
    xEdges = 0;
    sel = mode;
    pud = 0;
    if (e < 16) ev[e] = 1'b1;
    else pmx = 1'b1;
    @(posedge clk);
    #1;
    ev = '0;
    pmx = 0;
    repeat (5) @(posedge clk);
    #1;
    `CHK("holdInWait", 1'b1, hold)
    pud = 1;
    while (hold !== 1'b0 && n < 12000) begin
      @(posedge clk);
      #1;
      n++;
      if (pact === 1'b1) pc++;
    end
    `CHK("xtalEdges", 1'b1, xEdges >= wantX - 3 && xEdges <= wantX + 3)
    `CHK("pllCycles", 1'b1, pc >= wantP - 1 && pc <= wantP + 1)
    `CHK("holdEnd", 1'b0, hold)
    `CHK("pllEnable", mode == OSC_HIGH_SPEED_WITH_PLL_MODE, pllEn)
  endtask : startup
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    #400000;
    fails++;
    end_of_test();
  end
  initial begin
    void'($urandom(78));
    repeat (20) @(posedge clk);
    #1 reset_n = 1;
    `CHK("resetFlags", FLAGS_RESET, fl)
    `CHK("resetResume", {CLASS_POWER, RESUME_ZERO}, {rc, ra})
    startup(OSC_HIGH_SPEED_WITH_PLL_MODE, 3, 1024, PLL_LOCK_CYCLES);
    for (int m = 0; m < 4; m++) startup(3'(m), 16, 1024, 0);
    startup(3'h5, 2, 0, 0);
    startup(OSC_HIGH_SPEED_WITH_PLL_MODE, 5, 0, 0);
    for (int p = 0; p < 6; p++) begin
      pm = 2'(p % 3);
      global_interrupt_enable = 1'(p / 3);
      we = global_interrupt_enable;
      for (int e = 0; e < 16; e++) step(e, 1'b0, 13'h0000);
    end
    step(16, 1'b1, 13'h1fff);
    step(16, 1'b1, 13'h0000);
    repeat (1500) begin
      pm = 2'($urandom_range(2));
      global_interrupt_enable = 1'($urandom);
      we = 1'($urandom);
      safe = 1'($urandom);
      step($urandom_range(20), $urandom_range(3) == 0, 13'($urandom));
    end
    end_of_test();
  end
endmodule : test_rtcf_reset_timers
